// [common/tlm_pkg.sv]
// Package for the trigger and length measurement control block.
// Assumes one 10 MHz clock and a synchronous active-high reset in the user.
package tlm_pkg;
    // ==================================================================
    // Widths and ranges
    localparam int          SPD_W        = 16;      // Speed in 0.01 m/s steps
    localparam int          LEN_W        = 32;      // Length in device units
    localparam int          QUAL_W       = 8;       // Burst quality weight
    localparam int          ACC_W        = 40;      // Weighted sum width
    localparam int          WQ_W         = 16;      // Quality sum width
    localparam int          RING_DEPTH   = 32;      // Largest sliding window
    localparam int          IDX_W        = 5;
    localparam int          CNT_W        = 32;      // Object counter
    localparam int          NUM_SYNC_OUT = 6;       // Trigger-synchronous outputs
    localparam logic [2:0]  TRIG_MAX     = 3'h5;
    localparam logic [5:0]  WIN_MIN      = 6'h01;
    localparam logic [5:0]  WIN_MAX      = 6'h20;
    localparam logic [SPD_W-1:0] VMAX_MIN  = 16'h0001;  // 0.01 m/s
    localparam logic [SPD_W-1:0] VMAX_TOP  = 16'h2710;  // 100.00 m/s
    localparam logic [SPD_W-1:0] VMIN_RST  = 16'h0000;
    localparam logic [SPD_W-1:0] VMAX_RST  = 16'h2710;
    localparam logic [2:0]  TRIG_RST     = 3'h0;
    localparam logic [5:0]  WIN_RST      = 6'h01;
    // Averaging period
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          AVG_PERIOD_US = 1000;
    localparam int          AVG_CYCLES   = CLK_HZ / 1_000_000 * AVG_PERIOD_US;
    localparam int          AVG_CNT_W    = 14;

    // ==================================================================
    // Trigger types
    localparam logic [2:0]  TRIG_HIGH    = 3'h0;
    localparam logic [2:0]  TRIG_LOW     = 3'h1;
    localparam logic [2:0]  TRIG_RISE    = 3'h2;
    localparam logic [2:0]  TRIG_FALL    = 3'h3;
    localparam logic [2:0]  TRIG_AND     = 3'h4;
    localparam logic [2:0]  TRIG_AND_INV = 3'h5;

    // Barrier state machine states
    typedef enum logic [2:0] {
        TLM_BR_IDLE, TLM_BR_STOP_HI, TLM_BR_RUN, TLM_BR_WAIT_LOW
    } tlm_barrier_t;

    // One burst sample
    typedef struct packed {
        logic              valid;
        logic [SPD_W-1:0]  speed;
        logic [QUAL_W-1:0] quality;
    } tlm_burst_t;

    // Averaged result
    typedef struct packed {
        logic              valid;
        logic [SPD_W-1:0]  speed;
    } tlm_avg_t;
endpackage

// [src/tlm_avg.sv]
// Quality-weighted sliding average over a ring of per-period sums.
// Assumes bursts arrive at any cycle and one period tick per averaging period.
module tlm_avg (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire tlm_pkg::tlm_burst_t burst,
    input  wire logic              tick,
    input  wire logic [5:0]        depth,
    output tlm_pkg::tlm_avg_t      result
);
    // ==================================================================
    // Storage
    logic [tlm_pkg::ACC_W-1:0] ring_s [tlm_pkg::RING_DEPTH];
    logic [tlm_pkg::WQ_W-1:0]  ring_q [tlm_pkg::RING_DEPTH];
    logic [tlm_pkg::ACC_W-1:0] cur_s, next_cur_s;
    logic [tlm_pkg::WQ_W-1:0]  cur_q, next_cur_q;
    logic [tlm_pkg::IDX_W-1:0] wr_idx, next_wr_idx;
    tlm_pkg::tlm_avg_t         next_result;
    logic [tlm_pkg::ACC_W-1:0] tot_s;
    logic [tlm_pkg::WQ_W+5:0]  tot_q;
    logic [5:0]                eff;

    // Accumulate bursts weighted by quality, close a slot each tick
    always_comb begin
        next_cur_s  = cur_s;
        next_cur_q  = cur_q;
        next_wr_idx = wr_idx;
        next_result = result;
        next_result.valid = 1'b0;
        eff   = (depth < tlm_pkg::WIN_MIN) ? tlm_pkg::WIN_MIN :
                (depth > tlm_pkg::WIN_MAX) ? tlm_pkg::WIN_MAX : depth;
        tot_s = cur_s;
        tot_q = {6'h00, cur_q};
        // Window of eff periods: current plus eff-1 stored slots
        for (int i = 1; i < tlm_pkg::RING_DEPTH; i++) begin
            if (i < int'(eff)) begin
                tot_s = tot_s + ring_s[5'(int'(wr_idx) - i)];
                tot_q = tot_q + {6'h00, ring_q[5'(int'(wr_idx) - i)]};
            end
        end
        if (tick) begin
            next_result.valid = 1'b1;
            next_result.speed = (tot_q == '0) ? '0 : 16'(tot_s / 40'(tot_q));
            next_cur_s  = '0;
            next_cur_q  = '0;
            next_wr_idx = wr_idx + 5'h01;
        end
        // A burst on the tick cycle opens the next slot instead of being lost
        if (burst.valid) begin
            next_cur_s = next_cur_s + 40'(burst.speed) * 40'(burst.quality);
            next_cur_q = next_cur_q + 16'(burst.quality);
        end
    end

    // Register the state and the ring slot
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_s  <= '0;
            cur_q  <= '0;
            wr_idx <= '0;
            result <= '0;
            for (int i = 0; i < tlm_pkg::RING_DEPTH; i++) begin
                ring_s[i] <= '0;
                ring_q[i] <= '0;
            end
        end else begin
            cur_s  <= next_cur_s;
            cur_q  <= next_cur_q;
            wr_idx <= next_wr_idx;
            result <= next_result;
            if (tick) begin
                ring_s[wr_idx] <= cur_s;
                ring_q[wr_idx] <= cur_q;
            end
        end
    end

    // Result valid follows each tick
    avg_tick_a : assert property (@(posedge clk) disable iff (rst)
        tick |=> result.valid) else $error("Average not output on tick");
    avg_cov_c : cover property (@(posedge clk) tick && depth == 6'h08);
endmodule

// [src/tlm_ctrl.sv]
// Trigger, barrier and length integration control with speed suppression.
// Assumes trigger and barrier inputs are synchronous to CLK.
// How it works
// - Each recognised trigger adds one to count
// - Type 0..5 selects level, edge, barrier
// - Single part: active level runs integration
// - Edge types: each edge restarts measurement
// - Sync-selected outputs refresh at measurement stop
// - Types 4,5 use barrier machine, 5 inverted
// - Start on start-rise after stop-high, start-low
// - Stop on stop-fall while running both high
// - Wrong direction never starts a measurement
// - One barrier alone never starts a measurement
// - Reported length includes barrier spacing offset
// - Max speed limited to 0.01..100.00 m/s
// - Below threshold clear SPEED_OUT_EN, SPEED_OUT keeps last value
// - Threshold zero disables, reset value zero
// - Yellow when speed seen but below threshold
// - Threshold write of up to 100.00 m/s above max speed flags error
// - Ring of 1..32 averaging periods
// - Bursts weighted by their quality
// - Accumulate anytime, output once per period
// - Window 1..32, one disables averaging
// - Start command restarts integration from zero
// - Stop command halts only single-part mode
module tlm_ctrl (
    input  wire logic                          CLK,
    input  wire logic                          SYS_RST,
    input  wire logic                          TRIG_STOP_IN,
    input  wire logic                          START_BARRIER_INPUT,
    input  wire logic [2:0]                    TRIG_TYPE,
    input  wire logic                          START_CMD,
    input  wire logic                          STOP_CMD,
    input  wire logic [tlm_pkg::LEN_W-1:0]     LENGTH_INC,
    input  wire logic [tlm_pkg::LEN_W-1:0]     LENGTH_OFFSET,
    input  wire tlm_pkg::tlm_burst_t           BURST,
    input  wire logic [5:0]                    WINDOW_DEPTH,
    input  wire logic                          VMAX_WR,
    input  wire logic [tlm_pkg::SPD_W-1:0]     VMAX_IN,
    input  wire logic                          VMIN_WR,
    input  wire logic [tlm_pkg::SPD_W-1:0]     VMIN_IN,
    input  wire logic [tlm_pkg::NUM_SYNC_OUT-1:0] SYNC_SELECT,
    output logic [tlm_pkg::CNT_W-1:0]          OBJECT_COUNT,
    output logic                               MEAS_ACTIVE,
    output logic [tlm_pkg::LEN_W-1:0]          LENGTH_REPORT,
    output logic                               MEAS_DONE,
    output logic [tlm_pkg::NUM_SYNC_OUT-1:0]   SYNC_UPDATE,
    output logic [tlm_pkg::SPD_W-1:0]          SPEED_OUT,
    output logic                               SPEED_OUT_EN,
    output logic                               LED_YELLOW,
    output logic                               VMIN_ERROR,
    output logic [tlm_pkg::SPD_W-1:0]          VMAX_VALUE
);
    // ==================================================================
    // Input registers and edge detection
    logic a_q, b_q, a_p, b_p;
    logic start_ev, stop_ev, a_n, b_n, ap_n, bp_n;
    tlm_pkg::tlm_barrier_t br, next_br;
    logic [tlm_pkg::LEN_W-1:0] len, next_len;
    logic [tlm_pkg::CNT_W-1:0] next_cnt;
    logic next_active, next_done;
    logic [tlm_pkg::LEN_W-1:0] next_report;
    logic [tlm_pkg::NUM_SYNC_OUT-1:0] next_sync;
    logic [tlm_pkg::SPD_W-1:0] vmax, next_vmax, vmin, next_vmin;
    logic next_err, next_spd_en, next_led;
    logic [tlm_pkg::SPD_W-1:0] next_spd;
    logic [tlm_pkg::AVG_CNT_W-1:0] avg_cnt, next_avg_cnt;
    logic tick;
    tlm_pkg::tlm_avg_t avg;

    function automatic logic single_mode(input logic [2:0] t);
        single_mode = (t != tlm_pkg::TRIG_RISE) && (t != tlm_pkg::TRIG_FALL);
    endfunction

    // Register the inputs once and keep previous copy
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            a_p <= 1'b0;
            b_p <= 1'b0;
        end else begin
            a_q <= TRIG_STOP_IN;
            b_q <= START_BARRIER_INPUT;
            a_p <= a_q;
            b_p <= b_q;
        end
    end

    // ==================================================================
    // Barrier machine, inverted levels for type 5
    always_comb begin
        a_n  = (TRIG_TYPE == tlm_pkg::TRIG_AND_INV) ? ~a_q : a_q;
        b_n  = (TRIG_TYPE == tlm_pkg::TRIG_AND_INV) ? ~b_q : b_q;
        ap_n = (TRIG_TYPE == tlm_pkg::TRIG_AND_INV) ? ~a_p : a_p;
        bp_n = (TRIG_TYPE == tlm_pkg::TRIG_AND_INV) ? ~b_p : b_p;
        next_br = br;
        case (br)
            tlm_pkg::TLM_BR_IDLE: begin
                // Stop barrier alone first; start barrier first stays out
                if (a_n && !b_n)
                    next_br = tlm_pkg::TLM_BR_STOP_HI;
                else if (b_n)
                    next_br = tlm_pkg::TLM_BR_WAIT_LOW;
            end
            tlm_pkg::TLM_BR_STOP_HI: begin
                if (a_n && !bp_n && b_n)
                    next_br = tlm_pkg::TLM_BR_RUN;
                else if (!a_n)
                    next_br = tlm_pkg::TLM_BR_IDLE;
            end
            tlm_pkg::TLM_BR_RUN: begin
                if (ap_n && !a_n && b_n)
                    next_br = tlm_pkg::TLM_BR_WAIT_LOW;
                else if (!b_n)
                    next_br = a_n ? tlm_pkg::TLM_BR_STOP_HI : tlm_pkg::TLM_BR_IDLE;
            end
            default: next_br = tlm_pkg::TLM_BR_WAIT_LOW;
        endcase
        if (!a_n && !b_n)
            next_br = tlm_pkg::TLM_BR_IDLE;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            br <= tlm_pkg::TLM_BR_IDLE;
        else
            br <= next_br;
    end

    // ==================================================================
    // Trigger decode and length integration
    always_comb begin
        start_ev = 1'b0;
        stop_ev  = 1'b0;
        case (TRIG_TYPE)
            tlm_pkg::TRIG_HIGH: begin
                start_ev = a_q && !a_p;
                stop_ev  = !a_q && a_p;
            end
            tlm_pkg::TRIG_LOW: begin
                start_ev = !a_q && a_p;
                stop_ev  = a_q && !a_p;
            end
            tlm_pkg::TRIG_RISE: begin
                start_ev = a_q && !a_p;
                stop_ev  = start_ev;
            end
            tlm_pkg::TRIG_FALL: begin
                start_ev = !a_q && a_p;
                stop_ev  = start_ev;
            end
            tlm_pkg::TRIG_AND, tlm_pkg::TRIG_AND_INV: begin
                start_ev = (br == tlm_pkg::TLM_BR_STOP_HI) && (next_br == tlm_pkg::TLM_BR_RUN);
                stop_ev  = (br == tlm_pkg::TLM_BR_RUN) && (next_br == tlm_pkg::TLM_BR_WAIT_LOW);
            end
            default: ;
        endcase
        // Count follows start events only, so each object is counted once
        next_cnt    = OBJECT_COUNT + (start_ev ? 32'h1 : 32'h0);
        next_active = MEAS_ACTIVE;
        next_len    = MEAS_ACTIVE ? len + LENGTH_INC : len;
        next_done   = 1'b0;
        next_report = LENGTH_REPORT;
        next_sync   = '0;
        // A measurement stop publishes length and refreshes sync outputs
        if ((stop_ev && MEAS_ACTIVE) || (START_CMD && MEAS_ACTIVE && !single_mode(TRIG_TYPE)) ||
            (STOP_CMD && MEAS_ACTIVE && single_mode(TRIG_TYPE))) begin
            next_done   = 1'b1;
            next_report = next_len + LENGTH_OFFSET;
            next_sync   = SYNC_SELECT;
            next_active = 1'b0;
        end
        if (start_ev || START_CMD) begin
            next_active = 1'b1;
            next_len    = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OBJECT_COUNT  <= '0;
            MEAS_ACTIVE   <= 1'b0;
            len           <= '0;
            LENGTH_REPORT <= '0;
            MEAS_DONE     <= 1'b0;
            SYNC_UPDATE   <= '0;
        end else begin
            OBJECT_COUNT  <= next_cnt;
            MEAS_ACTIVE   <= next_active;
            len           <= next_len;
            LENGTH_REPORT <= next_report;
            MEAS_DONE     <= next_done;
            SYNC_UPDATE   <= next_sync;
        end
    end

    // ==================================================================
    // Averaging period divider and averager
    always_comb begin
        tick         = (avg_cnt == 14'(tlm_pkg::AVG_CYCLES - 1));
        next_avg_cnt = tick ? '0 : avg_cnt + 14'h0001;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            avg_cnt <= '0;
        else
            avg_cnt <= next_avg_cnt;
    end

    tlm_avg u_avg (
        .clk    (CLK),
        .rst    (SYS_RST),
        .burst  (BURST),
        .tick   (tick),
        .depth  (WINDOW_DEPTH),
        .result (avg)
    );

    // ==================================================================
    // Speed limits, suppression and indicator
    always_comb begin
        next_vmax = vmax;
        next_vmin = vmin;
        next_err  = VMIN_ERROR;
        if (VMAX_WR && VMAX_IN >= tlm_pkg::VMAX_MIN && VMAX_IN <= tlm_pkg::VMAX_TOP)
            next_vmax = VMAX_IN;
        if (VMIN_WR && VMIN_IN <= tlm_pkg::VMAX_TOP) begin
            next_vmin = VMIN_IN;
            next_err  = (VMIN_IN > vmax);
        end
        next_spd    = SPEED_OUT;
        next_spd_en = SPEED_OUT_EN;
        next_led    = LED_YELLOW;
        if (avg.valid) begin
            // Zero threshold disables suppression
            if (vmin != '0 && avg.speed < vmin) begin
                next_spd_en = 1'b0;
                next_led    = (avg.speed != '0);
            end else begin
                next_spd    = avg.speed;
                next_spd_en = 1'b1;
                next_led    = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            vmax         <= tlm_pkg::VMAX_RST;
            vmin         <= tlm_pkg::VMIN_RST;
            VMIN_ERROR   <= 1'b0;
            SPEED_OUT    <= '0;
            SPEED_OUT_EN <= 1'b0;
            LED_YELLOW   <= 1'b0;
            VMAX_VALUE   <= tlm_pkg::VMAX_RST;
        end else begin
            vmax         <= next_vmax;
            vmin         <= next_vmin;
            VMIN_ERROR   <= next_err;
            SPEED_OUT    <= next_spd;
            SPEED_OUT_EN <= next_spd_en;
            LED_YELLOW   <= next_led;
            VMAX_VALUE   <= next_vmax;
        end
    end

    // ==================================================================
    // Checks
    count_step_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        start_ev |=> OBJECT_COUNT == $past(OBJECT_COUNT) + 32'h1) else $error("Count step wrong");
    edge_restart_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (TRIG_TYPE == tlm_pkg::TRIG_RISE && a_q && !a_p && MEAS_ACTIVE) |=> MEAS_ACTIVE && MEAS_DONE)
        else $error("Edge did not restart");
    sync_update_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        MEAS_DONE |-> SYNC_UPDATE == $past(SYNC_SELECT)) else $error("Sync outputs not refreshed");
    wrong_dir_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (br == tlm_pkg::TLM_BR_IDLE && b_n) |=> (br == tlm_pkg::TLM_BR_WAIT_LOW && !start_ev))
        else $error("Start in wrong direction");
    barrier_idle_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (TRIG_TYPE == tlm_pkg::TRIG_AND && !a_q && !b_q) |=> br == tlm_pkg::TLM_BR_IDLE)
        else $error("Barrier machine not idle");
    offset_add_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (MEAS_DONE && !$past(START_CMD) && !$past(start_ev))
        |-> LENGTH_REPORT == $past(len) + $past(LENGTH_INC) + $past(LENGTH_OFFSET))
        else $error("Offset not added");
    suppress_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (avg.valid && vmin != '0 && avg.speed < vmin && !VMIN_WR) |=> !SPEED_OUT_EN)
        else $error("Speed not suppressed");
    vmin_err_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (VMIN_WR && VMIN_IN <= tlm_pkg::VMAX_TOP && VMIN_IN > vmax) |=> VMIN_ERROR)
        else $error("Threshold error missed");
    stop_cont_a : assert property (@(posedge CLK) disable iff (SYS_RST)
        (STOP_CMD && !START_CMD && !start_ev && MEAS_ACTIVE && !single_mode(TRIG_TYPE)) |=> MEAS_ACTIVE)
        else $error("Stop acted in continuous mode");
    barrier_cov_c : cover property (@(posedge CLK) stop_ev && TRIG_TYPE == tlm_pkg::TRIG_AND);
    inv_cov_c : cover property (@(posedge CLK) start_ev && TRIG_TYPE == tlm_pkg::TRIG_AND_INV);
    edge_cov_c : cover property (@(posedge CLK) stop_ev && TRIG_TYPE == tlm_pkg::TRIG_FALL);
endmodule

// [verif/tlm_barrier_model.sv]
// Light barrier and trigger source model for the control bench.
// Assumes go is held two cycles and that rst is the device reset.
module tlm_barrier_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       inv,
    input  wire logic [2:0] sel,
    output logic            stop_pin,
    output logic            start_pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==============================================================
    // Sequences of {stop, start} levels, step 0 in the low bits
    localparam logic [9:0] SEQ [7] = '{10'h078, 10'h0b4, 10'h008, 10'h004, 10'h008, 10'h088, 10'h0d2};
    localparam int         LEN [7] = '{5, 5, 3, 3, 2, 4, 5};
    localparam int         HOLD    = 6;
    logic [1:0]            lvl     = 2'h0;
    initial busy = 1'b0;
    // Inverted barriers read low when blocked
    assign stop_pin  = lvl[1] ^ inv;
    assign start_pin = lvl[0] ^ inv;
    // Play one sequence, each step held for several cycles
    always begin
        @(posedge clk);
        if (rst) begin
            #1 lvl = 2'h0;
        end else if (go && !busy) begin
            busy = 1'b1;
            for (int i = 0; i < LEN[sel]; i++) begin
                #1 lvl = SEQ[sel][2*i +: 2];
                repeat (HOLD) @(posedge clk);
            end
            busy = 1'b0;
        end
    end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the trigger and length measurement control.
// Assumes tlm_pkg, tlm_ctrl and the barrier model are compiled first.
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] t;
        logic       inv;
        logic [2:0] s;
        logic [3:0] cnt;
        logic       act;
        logic [3:0] dn;
    } tlm_row_t;
    // ==============================================================
    // Signals
    logic CLK, SYS_RST, TRIG_STOP_IN, START_BARRIER_INPUT, START_CMD, STOP_CMD, VMAX_WR, VMIN_WR;
    logic MEAS_ACTIVE, MEAS_DONE, SPEED_OUT_EN, LED_YELLOW, VMIN_ERROR, go, inv, busy;
    logic [2:0]  TRIG_TYPE, sel;
    logic [5:0]  WINDOW_DEPTH, SYNC_SELECT, SYNC_UPDATE;
    logic [15:0] VMAX_IN, VMIN_IN, SPEED_OUT, VMAX_VALUE;
    logic [31:0] LENGTH_INC, LENGTH_OFFSET, OBJECT_COUNT, LENGTH_REPORT;
    logic [3:0]  done_cnt;
    int          bad_count = 0;
    int          cmp_count = 0;
    tlm_pkg::tlm_burst_t BURST;
    tlm_row_t rows [11] = '{'{3'h0, 1'h0, 3'h5, 4'h2, 1'h1, 4'h1}, '{3'h1, 1'h1, 3'h5, 4'h2, 1'h1, 4'h1},
        '{3'h2, 1'h0, 3'h5, 4'h2, 1'h1, 4'h1}, '{3'h3, 1'h1, 3'h5, 4'h2, 1'h1, 4'h1},
        '{3'h4, 1'h0, 3'h0, 4'h1, 1'h0, 4'h1}, '{3'h5, 1'h1, 3'h0, 4'h1, 1'h0, 4'h1},
        '{3'h4, 1'h0, 3'h1, 4'h0, 1'h0, 4'h0}, '{3'h4, 1'h0, 3'h2, 4'h0, 1'h0, 4'h0},
        '{3'h4, 1'h0, 3'h3, 4'h0, 1'h0, 4'h0}, '{3'h4, 1'h0, 3'h4, 4'h0, 1'h0, 4'h0},
        '{3'h4, 1'h0, 3'h6, 4'h0, 1'h0, 4'h0}};
    tlm_ctrl tlm_ctrl_i (.CLK(CLK), .SYS_RST(SYS_RST), .TRIG_STOP_IN(TRIG_STOP_IN),
        .START_BARRIER_INPUT(START_BARRIER_INPUT), .TRIG_TYPE(TRIG_TYPE), .START_CMD(START_CMD),
        .STOP_CMD(STOP_CMD), .LENGTH_INC(LENGTH_INC), .LENGTH_OFFSET(LENGTH_OFFSET), .BURST(BURST),
        .WINDOW_DEPTH(WINDOW_DEPTH), .VMAX_WR(VMAX_WR), .VMAX_IN(VMAX_IN), .VMIN_WR(VMIN_WR),
        .VMIN_IN(VMIN_IN), .SYNC_SELECT(SYNC_SELECT), .OBJECT_COUNT(OBJECT_COUNT),
        .MEAS_ACTIVE(MEAS_ACTIVE), .LENGTH_REPORT(LENGTH_REPORT), .MEAS_DONE(MEAS_DONE),
        .SYNC_UPDATE(SYNC_UPDATE), .SPEED_OUT(SPEED_OUT), .SPEED_OUT_EN(SPEED_OUT_EN),
        .LED_YELLOW(LED_YELLOW), .VMIN_ERROR(VMIN_ERROR), .VMAX_VALUE(VMAX_VALUE));
    tlm_barrier_model tlm_barrier_model_i (.clk(CLK), .rst(SYS_RST), .go(go), .inv(inv), .sel(sel),
        .stop_pin(TRIG_STOP_IN), .start_pin(START_BARRIER_INPUT), .busy(busy));
    // ==============================================================
    // Clock, end-of-measurement tally and update-strobe watch
    always #50 CLK = ~CLK;
    always @(negedge CLK) begin
        done_cnt <= (SYS_RST || done_cnt === 4'hx) ? 4'h0 : done_cnt + {3'h0, MEAS_DONE === 1'b1};
        if (!SYS_RST) `CHK("sync_update", (MEAS_DONE === 1'b1) ? SYNC_SELECT : 6'h00, SYNC_UPDATE)
    end
    // ==============================================================
    // Helpers
    task automatic report_and_stop();
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic do_reset();
        SYS_RST = 1'b1;
        cyc(2);
        SYS_RST = 1'b0;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n = 0;
        while (s !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (s !== v) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic mx, input logic [15:0] v);
        if (mx) begin
            VMAX_IN = v;
            pulse(VMAX_WR);
        end else begin
            VMIN_IN = v;
            pulse(VMIN_WR);
        end
        cyc(3);
    endtask
    task automatic burst(input logic [15:0] v, input logic [7:0] q);
        BURST = '{valid: 1'b1, speed: v, quality: q};
        cyc(1);
        BURST.valid = 1'b0;
    endtask
    // ==============================================================
    // Main sequence
    initial begin
        {CLK, START_CMD, STOP_CMD, VMAX_WR, VMIN_WR, go, inv} = '0;
        {TRIG_TYPE, sel, LENGTH_INC, VMAX_IN, VMIN_IN} = '0;
        {SYS_RST, BURST, WINDOW_DEPTH, SYNC_SELECT, LENGTH_OFFSET} = {1'b1, 25'h0, 6'h01, 6'h2b, 32'h64};
        do_reset();
        `CHK("vmax_rst", 16'h2710, VMAX_VALUE)
        `CHK("count_rst", 32'h0, OBJECT_COUNT)
        // Table of trigger types and barrier sequences
        foreach (rows[r]) begin
            TRIG_TYPE = rows[r].t;
            inv = rows[r].inv;
            do_reset();
            sel = rows[r].s;
            go = 1'b1;
            cyc(2);
            go = 1'b0;
            wait_for(busy, 1'b0, 200);
            cyc(4);
            `CHK("count", {28'h0, rows[r].cnt}, OBJECT_COUNT)
            `CHK("active", rows[r].act, MEAS_ACTIVE)
            `CHK("done", rows[r].dn, done_cnt)
        end
        // Commands in single-part mode
        TRIG_TYPE = 3'h0;
        do_reset();
        pulse(START_CMD);
        cyc(3);
        `CHK("cmd_start", 1'b1, MEAS_ACTIVE)
        pulse(STOP_CMD);
        cyc(3);
        `CHK("cmd_stop", 1'b0, MEAS_ACTIVE)
        `CHK("len_offset", 32'h64, LENGTH_REPORT)
        // Commands in continuous mode
        TRIG_TYPE = 3'h2;
        LENGTH_INC = 32'h1;
        do_reset();
        pulse(START_CMD);
        cyc(20);
        pulse(STOP_CMD);
        cyc(3);
        `CHK("stop_ignored", 1'b1, MEAS_ACTIVE)
        pulse(START_CMD);
        cyc(3);
        `CHK("len_first", 32'h7d, LENGTH_REPORT)
        cyc(7);
        pulse(START_CMD);
        cyc(3);
        `CHK("len_restart", 32'h6f, LENGTH_REPORT)
        // Speed limits
        wr(1'b1, 16'h0000);
        `CHK("vmax_low", 16'h2710, VMAX_VALUE)
        wr(1'b1, 16'h2711);
        `CHK("vmax_high", 16'h2710, VMAX_VALUE)
        wr(1'b1, 16'h03e8);
        `CHK("vmax_set", 16'h03e8, VMAX_VALUE)
        wr(1'b0, 16'h07d0);
        `CHK("vmin_err", 1'b1, VMIN_ERROR)
        wr(1'b0, 16'h0064);
        `CHK("vmin_ok", 1'b0, VMIN_ERROR)
        // Weighted average above the threshold, then suppression below it
        burst(16'h0190, 8'h01);
        burst(16'h0320, 8'h03);
        cyc(10005);
        `CHK("wavg_en", 1'b1, SPEED_OUT_EN)
        `CHK("wavg", 16'h02bc, SPEED_OUT)
        `CHK("led_off", 1'b0, LED_YELLOW)
        burst(16'h0032, 8'h01);
        wait_for(LED_YELLOW, 1'b1, 21000);
        `CHK("suppress", 1'b0, SPEED_OUT_EN)
        wr(1'b0, 16'h0000);
        burst(16'h0032, 8'h01);
        cyc(10005);
        `CHK("no_suppress", 1'b1, SPEED_OUT_EN)
        `CHK("slow_speed", 16'h0032, SPEED_OUT)
        `CHK("led_clear", 1'b0, LED_YELLOW)
        report_and_stop();
    end
endmodule
